/* core/txqs_defines.svh */
/*
 * Register indices, field positions, reset values and queue limits of the
 * transmit queue status block.
 * Assumes inclusion from files that also import txqs_pkg.
 */
`ifndef TXQS_DEFINES_SVH
`define TXQS_DEFINES_SVH

// ============================================================
// Register indices (byte address is four times the index)
`define TXQS_IDX_LEVEL_LO 15'h7f62
`define TXQS_IDX_LEVEL_HI 15'h7f63
`define TXQS_IDX_RELEASE 15'h7f67
`define TXQS_IDX_IRQ_STAT 15'h7f68
`define TXQS_IDX_IRQ_MASK 15'h7f69

// ============================================================
// Field positions and reset values
`define TXQS_MODE_BIT 0
`define TXQS_LEVEL_RESET 8'h55
`define TXQS_RELEASE_RESET 8'h00
`define TXQS_IRQ_RESET 16'h0000

// ============================================================
// Queue depth and status pair codes
`define TXQS_QUEUE_MAX 3'h5
`define TXQS_PAIR_EMPTY 2'h2
`define TXQS_PAIR_FULL 2'h1
`define TXQS_PAIR_PART 2'h0
`define TXQS_PAIR_BAD 2'h3
`define TXQS_PAIR_RESET 2'h1

`endif

/* core/txqs_pkg.sv */
/*
 * Types shared by the transmit queue status block.
 * Assumes nothing of its surroundings.
 */
`default_nettype none
package txqs_pkg;
    typedef logic [2:0] txqs_count_t;
    typedef logic [7:0] txqs_epvec_t;
    typedef logic [15:0] txqs_pairs_t;
    typedef logic [31:0] txqs_word_t;
endpackage
`default_nettype wire

/* core/txqs_track_if.sv */
/*
 * Link between the register side and the queue tracker.
 * Assumes one clock shared by both ends.
 */
`timescale 1ns/1ps
`default_nettype none
interface txqs_track_if;
    import txqs_pkg::*;
    txqs_epvec_t push;
    txqs_epvec_t pop;
    txqs_epvec_t popTaken;
    txqs_epvec_t drained;
    txqs_epvec_t refused;
    txqs_pairs_t pairs;
    modport tracker (input push, input pop, output popTaken, output drained, output refused, output pairs);
    modport regs (output push, output pop, input popTaken, input drained, input refused, input pairs);
endinterface
`default_nettype wire

/* core/txqs_queue_track.sv */
/*
 * Packet counters for the transmit queues of endpoints 8 to 15 and their
 * two-bit status pairs.
 * Assumes push and pop pulses synchronous to clock, one per packet.
 */
`timescale 1ns/1ps
`default_nettype none
`include "txqs_defines.svh"
module txqs_queue_track
    import txqs_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic ce,
    txqs_track_if.tracker trk
);
    txqs_count_t count [8];
    txqs_count_t next_count [8];
    txqs_pairs_t next_pairs;
    txqs_pairs_t pairsQ;
    txqs_epvec_t popTakenQ, drainedQ, refusedQ;
    txqs_epvec_t next_popTaken, next_drained, next_refused;
    txqs_epvec_t touched;

    function automatic logic [1:0] pairOf(input txqs_count_t c);
        if (c == 3'h0) pairOf = `TXQS_PAIR_EMPTY;
        else if (c == `TXQS_QUEUE_MAX) pairOf = `TXQS_PAIR_FULL;
        else pairOf = `TXQS_PAIR_PART;
    endfunction

    // ============================================================
    // Counter update
    always_comb begin
        logic popOk;
        logic pushOk;
        popOk = 1'b0;
        pushOk = 1'b0;
        next_pairs = pairsQ;
        for (int i = 0; i < 8; i++) begin
            popOk = trk.pop[i] && (count[i] != 3'h0);
            pushOk = trk.push[i] && ((count[i] != `TXQS_QUEUE_MAX) || popOk);
            next_count[i] = count[i] + txqs_count_t'(pushOk) - txqs_count_t'(popOk);
            next_popTaken[i] = popOk;
            next_refused[i] = trk.push[i] && !pushOk;
            next_drained[i] = popOk && !pushOk && (count[i] == 3'h1);
            // Pair follows the count from the first movement on; never 11
            if (trk.push[i] || trk.pop[i]) begin
                next_pairs[2*i +: 2] = pairOf(next_count[i]); // see R02 see R03 see R04 see R05
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < 8; i++) begin
                count[i] <= 3'h0;
            end
            pairsQ <= {8{`TXQS_PAIR_RESET}}; // see R06
            popTakenQ <= 8'h00;
            drainedQ <= 8'h00;
            refusedQ <= 8'h00;
            touched <= 8'h00;
        end else if (ce) begin
            for (int i = 0; i < 8; i++) begin
                count[i] <= next_count[i];
            end
            pairsQ <= next_pairs;
            popTakenQ <= next_popTaken;
            drainedQ <= next_drained;
            refusedQ <= next_refused;
            touched <= touched | trk.push | trk.pop;
        end
    end

    assign trk.pairs = pairsQ;
    assign trk.popTaken = popTakenQ;
    assign trk.drained = drainedQ;
    assign trk.refused = refusedQ;

    for (genvar g = 0; g < 8; g++) begin : gChk
        emptyPair_a: assert property (@(posedge clock) disable iff (!nrst) // see R02
            touched[g] && count[g] == 3'h0 |-> pairsQ[2*g +: 2] == 2'h2)
            else $error("empty queue not shown as 10");
        fullPair_a: assert property (@(posedge clock) disable iff (!nrst) // see R03
            touched[g] && count[g] == 3'h5 |-> pairsQ[2*g +: 2] == 2'h1)
            else $error("full queue not shown as 01");
        partPair_a: assert property (@(posedge clock) disable iff (!nrst) // see R04
            touched[g] && count[g] inside {[3'h1:3'h4]} |-> pairsQ[2*g +: 2] == 2'h0)
            else $error("partly filled queue not shown as 00");
    end
endmodule // txqs_queue_track
`default_nettype wire

/* core/txqs_top.sv */
/*
 * Transmit queue status and page release control for endpoints 8 to 15,
 * reached by firmware over AHB-Lite.
 * Assumes a single AHB-Lite master, word transfers only, and push/pop
 * pulses from the serial engine synchronous to clock.
 */
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "txqs_defines.svh"
// Behaviour
// R01: Endpoints 8-15 get empty/full pairs, four per register, highest on top.
// R02: An endpoint with no queued packets reads as pair 10; here it stays 01 from reset until its first push or pop.
// R03: An endpoint with five queued packets reads as pair 01.
// R04: An endpoint with one to four queued packets reads as pair 00.
// R05: Pair value 11 is never produced.
// R06: Both level registers are read-only and reset to 0x55.
// R07: Mode 0 frees pages automatically; mode 1 keeps pages, still pops queue.
// R08: The release mode bit resets to 0, automatic release.
// R09: Firmware sets the mode once, never around a transmission.
// R10: In manual mode firmware frees each sent packet's pages itself.
// R11: Bits 7 to 1 of the release control register read zero, ignore writes.
module txqs_top
    import txqs_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [7:0] txPush,
    input wire logic [7:0] txPop,
    output logic [7:0] pageFree,
    output logic pageReleaseMode,
    output logic irq
);
    txqs_track_if trk ();

    txqs_queue_track uTrack (
        .clock(clock),
        .nrst(nrst),
        .ce(ce),
        .trk(trk)
    );

    assign trk.push = txPush;
    assign trk.pop = txPop;

    // ============================================================
    // Address decode
    function automatic logic regHit(input logic [31:0] addr, input logic [14:0] idx);
        regHit = (addr[31:17] == 15'h0000) && (addr[16:2] == idx) && (addr[1:0] == 2'h0);
    endfunction

    logic mode;
    logic next_mode;
    txqs_pairs_t irqStat;
    txqs_pairs_t next_irqStat;
    txqs_pairs_t irqMask;
    txqs_pairs_t next_irqMask;
    txqs_word_t next_hrdata;
    txqs_epvec_t next_pageFree;
    logic wrRelease, wrStat, wrMask;
    logic next_wrRelease, next_wrStat, next_wrMask;
    logic rdPhase, next_rdPhase;
    logic [14:0] rdIdx, next_rdIdx;
    logic addrPhase;
    txqs_pairs_t events;

    assign addrPhase = hsel && hready && htrans[1];

    // ============================================================
    // Bus address phase
    always_comb begin
        next_wrRelease = 1'b0;
        next_wrStat = 1'b0;
        next_wrMask = 1'b0;
        next_rdPhase = 1'b0;
        next_rdIdx = 15'h0000;
        next_hrdata = hrdata;
        if (addrPhase && hwrite) begin
            // Level registers take no write: no strobe is decoded for them
            next_wrRelease = regHit(haddr, `TXQS_IDX_RELEASE); // see R06
            next_wrStat = regHit(haddr, `TXQS_IDX_IRQ_STAT);
            next_wrMask = regHit(haddr, `TXQS_IDX_IRQ_MASK);
        end else if (addrPhase) begin
            next_rdPhase = 1'b1;
            next_rdIdx = haddr[16:2];
            if (regHit(haddr, `TXQS_IDX_LEVEL_LO)) begin
                next_hrdata = {24'h000000, trk.pairs[7:0]}; // see R01
            end else if (regHit(haddr, `TXQS_IDX_LEVEL_HI)) begin
                next_hrdata = {24'h000000, trk.pairs[15:8]}; // see R01
            end else if (regHit(haddr, `TXQS_IDX_RELEASE)) begin
                next_hrdata = {31'h00000000, mode}; // see R11
            end else if (regHit(haddr, `TXQS_IDX_IRQ_STAT)) begin
                next_hrdata = {16'h0000, irqStat};
            end else if (regHit(haddr, `TXQS_IDX_IRQ_MASK)) begin
                next_hrdata = {16'h0000, irqMask};
            end else begin
                next_hrdata = 32'h00000000;
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            wrRelease <= 1'b0;
            wrStat <= 1'b0;
            wrMask <= 1'b0;
            rdPhase <= 1'b0;
            rdIdx <= 15'h0000;
            hrdata <= 32'h00000000;
        end else if (ce) begin
            wrRelease <= next_wrRelease;
            wrStat <= next_wrStat;
            wrMask <= next_wrMask;
            rdPhase <= next_rdPhase;
            rdIdx <= next_rdIdx;
            hrdata <= next_hrdata;
        end
    end

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // ============================================================
    // Control and interrupt registers
    assign events = {trk.refused, trk.drained};

    always_comb begin
        next_mode = mode;
        next_irqMask = irqMask;
        if (wrRelease) begin
            next_mode = hwdata[`TXQS_MODE_BIT]; // see R07 see R11
        end
        if (wrMask) begin
            next_irqMask = hwdata[15:0];
        end
        // Set wins over a write-one clear in the same cycle
        next_irqStat = events | (irqStat & ~(wrStat ? hwdata[15:0] : 16'h0000));
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            mode <= 1'(`TXQS_RELEASE_RESET); // see R08
            irqStat <= `TXQS_IRQ_RESET;
            irqMask <= `TXQS_IRQ_RESET;
        end else if (ce) begin
            mode <= next_mode;
            irqStat <= next_irqStat;
            irqMask <= next_irqMask;
        end
    end

    assign irq = |(irqStat & irqMask);
    assign pageReleaseMode = mode;

    // ============================================================
    // Page release after a transmitted packet leaves its queue
    always_comb begin
        next_pageFree = trk.popTaken & {8{~mode}}; // see R07
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pageFree <= 8'h00;
        end else if (ce) begin
            pageFree <= next_pageFree;
        end
    end

    // ============================================================
    // Checks
    pairValid_a: assert property (@(posedge clock) disable iff (!nrst) // see R05
        !((trk.pairs[1:0] == 2'h3) || (trk.pairs[3:2] == 2'h3) || (trk.pairs[5:4] == 2'h3)
        || (trk.pairs[7:6] == 2'h3) || (trk.pairs[9:8] == 2'h3) || (trk.pairs[11:10] == 2'h3)
        || (trk.pairs[13:12] == 2'h3) || (trk.pairs[15:14] == 2'h3)))
        else $error("invalid status pair 11");

    levelReset_a: assert property (@(posedge clock) disable iff (!nrst) // see R06
        $rose(nrst) |-> trk.pairs == 16'h5555)
        else $error("level registers not 0x55 after reset");

    modeReset_a: assert property (@(posedge clock) disable iff (!nrst) // see R08
        $rose(nrst) |-> !mode)
        else $error("release mode not cleared after reset");

    levelPacking_a: assert property (@(posedge clock) disable iff (!nrst) // see R01
        ce && addrPhase && !hwrite && regHit(haddr, 15'h7f63) |=> hrdata == {24'h0, $past(trk.pairs[15:8])})
        else $error("upper level register packing wrong");

    autoRelease_a: assert property (@(posedge clock) disable iff (!nrst) // see R07
        ce && !mode && (trk.popTaken != 8'h00) |=> pageFree == $past(trk.popTaken))
        else $error("automatic page release missing");

    manualHold_a: assert property (@(posedge clock) disable iff (!nrst) // see R07
        ce && mode |=> pageFree == 8'h00)
        else $error("pages released in manual mode");

    reservedZero_a: assert property (@(posedge clock) disable iff (!nrst) // see R11
        rdPhase && rdIdx == 15'h7f67 |-> hrdata[31:1] == 31'h0)
        else $error("reserved release bits not zero");

    levelReadOnly_a: assert property (@(posedge clock) disable iff (!nrst) // see R06
        !$stable(trk.pairs) |-> $past(txPush != 8'h00 || txPop != 8'h00))
        else $error("level register changed without queue movement");

    modeWrite_a: assert property (@(posedge clock) disable iff (!nrst) // see R07
        ce && wrRelease |=> mode == $past(hwdata[0]))
        else $error("release mode write lost");

    levelLoPacking_a: assert property (@(posedge clock) disable iff (!nrst) // see R01
        ce && addrPhase && !hwrite && regHit(haddr, `TXQS_IDX_LEVEL_LO) |=> hrdata == {24'h0, $past(trk.pairs[7:0])})
        else $error("lower level register packing wrong");

    levelNoWrite_a: assert property (@(posedge clock) disable iff (!nrst) // see R06
        ce && addrPhase && hwrite && (regHit(haddr, `TXQS_IDX_LEVEL_LO) || regHit(haddr, `TXQS_IDX_LEVEL_HI))
        |=> !wrRelease && !wrStat && !wrMask)
        else $error("write strobe raised for a level register");

    releaseRead_a: assert property (@(posedge clock) disable iff (!nrst) // see R11
        ce && addrPhase && !hwrite && regHit(haddr, `TXQS_IDX_RELEASE) |=> hrdata == {31'h0, $past(mode)})
        else $error("release register read wrong");

    statRead_a: assert property (@(posedge clock) disable iff (!nrst)
        ce && addrPhase && !hwrite && regHit(haddr, `TXQS_IDX_IRQ_STAT) |=> hrdata == {16'h0, $past(irqStat)})
        else $error("status register read wrong");

    maskRead_a: assert property (@(posedge clock) disable iff (!nrst)
        ce && addrPhase && !hwrite && regHit(haddr, `TXQS_IDX_IRQ_MASK) |=> hrdata == {16'h0, $past(irqMask)})
        else $error("mask register read wrong");

    unmappedRead_a: assert property (@(posedge clock) disable iff (!nrst)
        ce && addrPhase && !hwrite && !regHit(haddr, `TXQS_IDX_LEVEL_LO) && !regHit(haddr, `TXQS_IDX_LEVEL_HI)
        && !regHit(haddr, `TXQS_IDX_RELEASE) && !regHit(haddr, `TXQS_IDX_IRQ_STAT)
        && !regHit(haddr, `TXQS_IDX_IRQ_MASK) |=> hrdata == 32'h0)
        else $error("unmapped read not zero");

    readDataHold_a: assert property (@(posedge clock) disable iff (!nrst)
        !(ce && addrPhase && !hwrite) |=> $stable(hrdata))
        else $error("read data changed without a read");

    modeHold_a: assert property (@(posedge clock) disable iff (!nrst) // see R07
        !(ce && wrRelease) |=> $stable(mode))
        else $error("release mode changed without a write");

    ceFreezeRegs_a: assert property (@(posedge clock) disable iff (!nrst)
        !ce |=> $stable(irqStat) && $stable(irqMask) && $stable(pageFree))
        else $error("register state moved while clock enable low");

    ceFreezeBus_a: assert property (@(posedge clock) disable iff (!nrst)
        !ce |=> $stable(wrRelease) && $stable(wrStat) && $stable(wrMask) && $stable(rdPhase))
        else $error("bus state moved while clock enable low");

    ceFreezeLevel_a: assert property (@(posedge clock) disable iff (!nrst)
        !ce |=> $stable(trk.pairs) && $stable(trk.popTaken))
        else $error("queue state moved while clock enable low");

    eventSet_a: assert property (@(posedge clock) disable iff (!nrst)
        ce && events != 16'h0 |=> (irqStat & $past(events)) == $past(events))
        else $error("queue event did not set its status bit");

    statSticky_a: assert property (@(posedge clock) disable iff (!nrst)
        ce && !wrStat |=> (irqStat & $past(irqStat)) == $past(irqStat))
        else $error("status bit dropped without a clear");

    clearOne_a: assert property (@(posedge clock) disable iff (!nrst)
        ce && wrStat && events == 16'h0 |=> (irqStat & $past(hwdata[15:0])) == 16'h0)
        else $error("write of one did not clear status");

    maskWrite_a: assert property (@(posedge clock) disable iff (!nrst)
        ce && wrMask |=> irqMask == $past(hwdata[15:0]))
        else $error("mask write lost");

    irqRaise_a: assert property (@(posedge clock) disable iff (!nrst)
        ce && !wrMask && (events & irqMask) != 16'h0 |=> irq)
        else $error("unmasked event did not raise the interrupt");

    pageFreeSource_a: assert property (@(posedge clock) disable iff (!nrst) // see R07
        $past(ce) |-> (pageFree & ~$past(trk.popTaken)) == 8'h00)
        else $error("page release without a popped packet");

    resetOutputs_a: assert property (@(posedge clock) disable iff (!nrst)
        $rose(nrst) |-> !irq && pageFree == 8'h00 && hrdata == 32'h0)
        else $error("outputs not idle after reset");

    writeNoRead_a: assert property (@(posedge clock) disable iff (!nrst)
        ce && addrPhase && hwrite |=> !rdPhase)
        else $error("write taken as a read");

    readNoWrite_a: assert property (@(posedge clock) disable iff (!nrst)
        ce && addrPhase && !hwrite |=> rdPhase && !wrRelease && !wrStat && !wrMask)
        else $error("read taken as a write");

    idleNoStrobe_a: assert property (@(posedge clock) disable iff (!nrst)
        ce && !addrPhase |=> !wrRelease && !wrStat && !wrMask && !rdPhase)
        else $error("strobe raised without a transfer");
endmodule // txqs_top
`default_nettype wire

/* dv/tx_queue_status_dealloc_test.sv */
/*
 * Self-checking bench for the transmit queue status block: register
 * reset values, status pairs, page release mode and the interrupt.
 * Assumes txqs_top as a zero-wait AHB-Lite slave and the defines header.
 */
`timescale 1ns/1ps
`default_nettype none
`include "txqs_defines.svh"
module tx_queue_status_dealloc_test
    import txqs_pkg::*;
;
    localparam logic [31:0] ADDR_LO = 32'(`TXQS_IDX_LEVEL_LO) * 4;
    localparam logic [31:0] ADDR_HI = 32'(`TXQS_IDX_LEVEL_HI) * 4;
    localparam logic [31:0] ADDR_REL = 32'(`TXQS_IDX_RELEASE) * 4;
    localparam logic [31:0] ADDR_STAT = 32'(`TXQS_IDX_IRQ_STAT) * 4;
    localparam logic [31:0] ADDR_MASK = 32'(`TXQS_IDX_IRQ_MASK) * 4;
    logic clock, nrst, ce, hsel, hwrite, hreadyout, hresp, pageReleaseMode, irq;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [7:0] txPush, txPop, pageFree, seen, m;
    logic [15:0] expStat;
    logic mode;
    int error_cnt, checks, cycles;
    int cnt [8];

    txqs_top u_txqs_top (.clock(clock), .nrst(nrst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .txPush(txPush), .txPop(txPop), .pageFree(pageFree),
        .pageReleaseMode(pageReleaseMode), .irq(irq));

    // ============================================================
    // Clock and timeout
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            $display("ERROR %0t: timeout", $time);
            stop_test();
        end
    end

    // ============================================================
    // Checking and bus tasks
    task automatic check(input logic [31:0] seenVal, input logic [31:0] expVal);
        checks++;
        if (seenVal !== expVal) begin
            error_cnt++;
            $display("ERROR %0t: seen %h expected %h", $time, seenVal, expVal);
        end
    endtask

    task automatic waitReady();
        int n;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        if (n >= 100) check(32'h1, 32'h0);
    endtask

    task automatic bus(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
            output logic [31:0] rdata);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= addr;
        hwrite <= wr;
        waitReady();
        htrans <= 2'b00;
        hwdata <= wdata;
        waitReady();
        rdata = hrdata;
    endtask

    task automatic wrReg(input logic [31:0] addr, input logic [31:0] data);
        logic [31:0] rd;
        bus(1'b1, addr, data, rd);
    endtask

    task automatic rdChk(input logic [31:0] addr, input logic [31:0] expVal);
        logic [31:0] rd;
        bus(1'b0, addr, 32'h0, rd);
        check(rd, expVal);
        check({31'h0, hresp}, 32'h0);
    endtask

    // Samples a level output once the last write has landed
    task automatic sigChk(input logic isIrq, input logic expVal);
        @(negedge clock);
        check({31'h0, isIrq ? irq : pageReleaseMode}, {31'h0, expVal});
        @(posedge clock);
    endtask

    // ============================================================
    // Queue model and stimulus
    function automatic logic [1:0] pairOf(input int i);
        if (!seen[i]) return 2'b01;
        if (cnt[i] == 0) return 2'b10;
        if (cnt[i] == 5) return 2'b01;
        return 2'b00;
    endfunction

    function automatic logic [31:0] level(input int base);
        level = 32'h0;
        for (int i = 0; i < 4; i++) level[2*i +: 2] = pairOf(base + i);
    endfunction

    task automatic push(input logic [7:0] mask);
        txPush <= mask;
        @(posedge clock);
        for (int i = 0; i < 8; i++) begin
            if (mask[i]) begin
                seen[i] = 1'b1;
                if (cnt[i] == 5) expStat[8+i] = 1'b1;
                else cnt[i]++;
            end
        end
        txPush <= 8'h00;
        @(posedge clock);
    endtask

    task automatic pop(input logic [7:0] mask);
        logic [7:0] eff;
        eff = 8'h00;
        txPop <= mask;
        @(posedge clock);
        for (int i = 0; i < 8; i++) begin
            if (mask[i]) begin
                seen[i] = 1'b1;
                if (cnt[i] > 0) begin
                    cnt[i]--;
                    eff[i] = !mode;
                    if (cnt[i] == 0) expStat[i] = 1'b1;
                end
            end
        end
        txPop <= 8'h00;
        @(posedge clock);
        @(negedge clock);
        check({24'h0, pageFree}, {24'h0, eff});
        @(posedge clock);
        @(negedge clock);
        check({24'h0, pageFree}, 32'h0);
        @(posedge clock);
    endtask

    task automatic stop_test();
        $display("Checks %0d, errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // ============================================================
    // Main sequence
    initial begin
        error_cnt = 0;
        checks = 0;
        cycles = 0;
        seen = 8'h00;
        expStat = 16'h0000;
        mode = 1'b0;
        for (int i = 0; i < 8; i++) cnt[i] = 0;
        nrst = 1'b0;
        ce = 1'b1;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        txPush = 8'h00;
        txPop = 8'h00;
        repeat (12) @(posedge clock);
        nrst <= 1'b1;
        rdChk(ADDR_LO, 32'h55);
        rdChk(ADDR_HI, 32'h55);
        rdChk(ADDR_REL, 32'h0);
        sigChk(1'b0, 1'b0);
        wrReg(ADDR_LO, 32'h0);
        wrReg(ADDR_HI, 32'hff);
        rdChk(ADDR_LO, 32'h55);
        rdChk(ADDR_HI, 32'h55);
        rdChk(32'h100, 32'h0);
        wrReg(ADDR_REL, 32'hff);
        rdChk(ADDR_REL, 32'h1);
        sigChk(1'b0, 1'b1);
        wrReg(ADDR_REL, 32'h0);
        for (int k = 1; k < 8; k++) push(8'(8'hff << k));
        rdChk(ADDR_LO, level(0));
        rdChk(ADDR_HI, level(4));
        rdChk(ADDR_STAT, {16'h0, expStat});
        sigChk(1'b1, 1'b0);
        wrReg(ADDR_MASK, 32'hffff);
        rdChk(ADDR_MASK, 32'hffff);
        sigChk(1'b1, 1'b1);
        for (int r = 0; r < 5; r++) begin
            for (int i = 0; i < 8; i++) m[i] = (cnt[i] > 0);
            pop(m);
        end
        rdChk(ADDR_LO, level(0));
        rdChk(ADDR_HI, level(4));
        wrReg(ADDR_REL, 32'h1);
        mode = 1'b1;
        push(8'h01);
        pop(8'h01);
        pop(8'h01);
        // A push to queue 0 while clock enable is low must leave that queue as it was
        ce <= 1'b0;
        txPush <= 8'h01;
        @(posedge clock);
        ce <= 1'b1;
        txPush <= 8'h00;
        rdChk(ADDR_LO, level(0));
        rdChk(ADDR_STAT, {16'h0, expStat});
        wrReg(ADDR_MASK, 32'h0);
        sigChk(1'b1, 1'b0);
        wrReg(ADDR_MASK, 32'hffff);
        wrReg(ADDR_STAT, 32'hffff);
        expStat = 16'h0000;
        rdChk(ADDR_STAT, 32'h0);
        sigChk(1'b1, 1'b0);
        stop_test();
    end
endmodule // tx_queue_status_dealloc_test
`default_nettype wire
